// >>> hw/sacs_pkg.sv
// shared constants, types and register map of the converter control sequencer
package sacs_pkg;

	// clock and timing
	localparam int CLK_MHZ         = 50;
	localparam int FIRST_ON_US     = 500;
	localparam int FAST_ON_US      = 5;
	localparam int FIRST_ON_CYC    = FIRST_ON_US * CLK_MHZ;
	localparam int FAST_ON_CYC     = FAST_ON_US * CLK_MHZ - 1;
	localparam int CONV_TICKS      = 16;
	localparam int SER_WAIT_TICKS  = 3;
	localparam int RESULT_BITS     = 8;
	localparam int PAR_WAIT_TICKS  = 10;
	localparam int PAR_HOLD_TICKS  = 32;

	// sample period in system clocks for each speed code
	localparam int RATE_5K_CYC     = CLK_MHZ * 1000 / 5;
	localparam int RATE_10K_CYC    = CLK_MHZ * 1000 / 10;
	localparam int RATE_20K_CYC    = CLK_MHZ * 1000 / 20;
	localparam int RATE_100K_CYC   = CLK_MHZ * 1000 / 100;

	// register word addresses
	localparam logic [3:0] ADDR_CONFIG = 4'h0;
	localparam logic [3:0] ADDR_TRIM   = 4'h1;
	localparam logic [3:0] ADDR_STATUS = 4'h2;

	// reset values
	localparam logic [17:0] CONFIG_RESET = 18'h00000;
	localparam logic [7:0]  TRIM_RESET   = 8'h00;

	// conversion clock source codes
	localparam logic [1:0] CLK_RING   = 2'h0;
	localparam logic [1:0] CLK_MATRIX = 2'h1;
	localparam logic [1:0] CLK_RC     = 2'h2;
	localparam logic [1:0] CLK_SPI    = 2'h3;

	// reference codes
	localparam logic [1:0] REF_QUARTER = 2'h2;
	localparam logic [1:0] REF_NONE    = 2'h3;

	// configuration word, msb first
	typedef struct packed {
		logic       vdd_div_en;
		logic       pga_out_en;
		logic       fast_power_on;
		logic       wake_sleep_en;
		logic       native_trim_in;
		logic       multichannel_en;
		logic       trim_src_sel;
		logic [1:0] vref_sel;
		logic [1:0] speed_sel;
		logic       pseudo_diff_en;
		logic [2:0] gain_sel;
		logic       differential;
		logic [1:0] clk_sel;
	} sacs_config_type;

	// analog front-end steering bundle
	typedef struct packed {
		logic       diff_mode;
		logic       neg_from_trim;
		logic       pos_from_first;
		logic       native_trim_in;
		logic       pga_out_en;
		logic [2:0] gain_code;
		logic [1:0] vref_code;
		logic       vref_valid;
	} sacs_analog_type;

endpackage

// >>> hw/sacs_sequencer.sv
// control sequencer for the 8-bit successive-approximation converter
`timescale 1ns/1ps

module sacs_sequencer
	import sacs_pkg::*;
#(
	parameter int FIRST_ON_CYCLES = FIRST_ON_CYC,
	parameter int RATE_5K         = RATE_5K_CYC,
	parameter int RATE_10K        = RATE_10K_CYC,
	parameter int RATE_20K        = RATE_20K_CYC,
	parameter int RATE_100K       = RATE_100K_CYC
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	// register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	output logic      [31:0] reg_rdata,
	// candidate conversion clocks, sampled as levels
	input  wire logic        ring_osc,
	input  wire logic        matrix_clock_route,
	input  wire logic        rc_osc,
	input  wire logic        spi_sclk,
	// matrix and pins
	input  wire logic        power_down_route,
	input  wire logic        channel_select_pin,
	input  wire logic [7:0]  dcmp1_input,
	input  wire logic        comparator_high,
	// analog control
	output sacs_analog_type  analog_ctrl,
	output logic             adc_power_down,
	output logic             pga_power_down,
	output logic             analog_block_on,
	output logic             sample_hold,
	output logic      [7:0]  sar_trial,
	output logic      [7:0]  trim_code,
	// results
	output logic             serial_result,
	output logic             serial_result_oe_n,
	output logic      [7:0]  parallel_result,
	output logic             parallel_valid,
	output logic             conversion_irq
);

	typedef enum logic [1:0] {
		SACS_PW_OFF  = 2'b00,
		SACS_PW_WARM = 2'b01,
		SACS_PW_ON   = 2'b11
	} sacs_power_type;

	typedef enum logic [1:0] {
		SACS_CV_IDLE = 2'b00,
		SACS_CV_RUN  = 2'b01
	} sacs_conv_type;

	sacs_config_type cfg;
	logic      [7:0] trim_reg;
	sacs_power_type  pw_state;
	logic     [15:0] warm_cnt;
	logic            analog_up;
	sacs_conv_type   cv_state;
	logic      [3:0] phase;
	logic      [7:0] last_result;
	logic     [15:0] rate_cnt;
	logic            start_pend;
	logic            src_prev;
	logic            tick;
	logic            src_now;
	logic            pd_eff;
	logic            pd_prev;
	logic            ro_active;
	logic      [5:0] ro_cnt;
	logic      [5:0] next_ro_cnt;
	logic      [7:0] ro_snap;
	logic     [15:0] rate_period;
	logic      [2:0] bit_idx;

	// conversion clock source mux
	always_comb begin
		unique case (cfg.clk_sel)
			CLK_RING:   src_now = ring_osc;
			CLK_MATRIX: src_now = matrix_clock_route;
			CLK_RC:     src_now = rc_osc;
			CLK_SPI:    src_now = spi_sclk;
		endcase
	end

	// rising edge of the chosen source becomes one tick
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			src_prev <= 1'b0;
		end else begin
			src_prev <= src_now;
		end
	end

	assign tick = src_now & ~src_prev;

	// register writes
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cfg      <= CONFIG_RESET;
			trim_reg <= TRIM_RESET;
		end else if (reg_write) begin
			if (reg_addr == ADDR_CONFIG) begin
				cfg <= reg_wdata[17:0];
			end
			if (reg_addr == ADDR_TRIM) begin
				trim_reg <= reg_wdata[7:0];
			end
		end
	end

	// register reads, data valid one cycle after the strobe
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_read) begin
			unique case (reg_addr)
				ADDR_CONFIG: reg_rdata <= {14'h0000, cfg};
				ADDR_TRIM:   reg_rdata <= {24'h000000, trim_reg};
				ADDR_STATUS: reg_rdata <= {20'h00000, ro_active, cv_state == SACS_CV_RUN,
					pw_state == SACS_PW_ON, analog_block_on, last_result};
				default:     reg_rdata <= 32'h00000000;
			endcase
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end

	// power-down takes effect only with wake/sleep enabled
	assign pd_eff = power_down_route & cfg.wake_sleep_en;

	// converter and amplifier both follow the power-down route
	assign adc_power_down = pd_eff;
	assign pga_power_down = pd_eff;

	// slow mode drops the whole analog block, fast mode keeps it
	assign analog_block_on = ~(pd_eff & ~cfg.fast_power_on);

	// power-up sequencing with slow first start and fast rewake
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pw_state  <= SACS_PW_OFF;
			warm_cnt  <= 16'h0000;
			analog_up <= 1'b0;
		end else begin
			if (!analog_block_on) begin
				analog_up <= 1'b0;
			end
			unique case (pw_state)
				SACS_PW_OFF: begin
					if (!pd_eff) begin
						pw_state <= SACS_PW_WARM;
						if (analog_up && cfg.fast_power_on) begin
							warm_cnt <= 16'(FAST_ON_CYC);
						end else begin
							warm_cnt <= 16'(FIRST_ON_CYCLES - 1);
						end
					end
				end
				SACS_PW_WARM: begin
					if (pd_eff) begin
						pw_state <= SACS_PW_OFF;
					end else if (warm_cnt == 16'h0000) begin
						pw_state  <= SACS_PW_ON;
						analog_up <= 1'b1;
					end else begin
						warm_cnt <= warm_cnt - 16'h0001;
					end
				end
				SACS_PW_ON: begin
					if (pd_eff) begin
						pw_state <= SACS_PW_OFF;
					end
				end
				default: pw_state <= SACS_PW_OFF;
			endcase
		end
	end

	// sample period from speed field
	always_comb begin
		unique case (cfg.speed_sel)
			2'h0: rate_period = 16'(RATE_5K - 1);
			2'h1: rate_period = 16'(RATE_10K - 1);
			2'h2: rate_period = 16'(RATE_20K - 1);
			2'h3: rate_period = 16'(RATE_100K - 1);
		endcase
	end

	// sample-rate timer raises a start request once per period
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rate_cnt   <= 16'h0000;
			start_pend <= 1'b0;
		end else if (pw_state != SACS_PW_ON) begin
			rate_cnt   <= 16'h0000;
			start_pend <= 1'b0;
		end else begin
			if (rate_cnt >= rate_period) begin
				rate_cnt   <= 16'h0000;
				start_pend <= 1'b1;
			end else begin
				rate_cnt <= rate_cnt + 16'h0001;
				if (cv_state == SACS_CV_IDLE && tick) begin
					start_pend <= 1'b0;
				end
			end
		end
	end

	// bit under trial for phases 1..8
	assign bit_idx = 3'(4'd8 - phase);

	// sixteen-tick conversion: sample, eight trials, settle, result
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cv_state       <= SACS_CV_IDLE;
			phase          <= 4'h0;
			sar_trial      <= 8'h00;
			last_result    <= 8'h00;
			sample_hold    <= 1'b0;
			conversion_irq <= 1'b0;
		end else begin
			conversion_irq <= 1'b0;
			unique case (cv_state)
				SACS_CV_IDLE: begin
					if (pw_state == SACS_PW_ON && start_pend && tick) begin
						cv_state    <= SACS_CV_RUN;
						phase       <= 4'h0;
						sample_hold <= 1'b1;
					end
				end
				SACS_CV_RUN: begin
					if (pw_state != SACS_PW_ON) begin
						cv_state    <= SACS_CV_IDLE;
						sample_hold <= 1'b0;
					end else if (tick) begin
						phase <= phase + 4'h1;
						if (phase == 4'h0) begin
							sample_hold <= 1'b0;
							sar_trial   <= 8'h80;
						end else if (phase <= 4'h8) begin
							sar_trial[bit_idx] <= comparator_high;
							if (bit_idx != 3'h0) begin
								sar_trial[bit_idx - 3'h1] <= 1'b1;
							end
						end
						// the start tick samples, so sixteen ticks end at phase fourteen;
						// waiting for phase fifteen would stretch every conversion by one
						// tick but slow only the sample rates whose period is shorter than a conversion
						if (phase == 4'(CONV_TICKS - 2)) begin
							last_result    <= sar_trial;
							conversion_irq <= 1'b1;
							cv_state       <= SACS_CV_IDLE;
						end
					end
				end
				default: cv_state <= SACS_CV_IDLE;
			endcase
		end
	end

	// readout starts on the rising edge of the power-down route;
	// the raw route is watched so matrix logic can read results even
	// while wake/sleep is disabled and the converter stays powered;
	// the snapshot holds the last finished conversion, never a partial one
	assign next_ro_cnt = ro_cnt + 6'h01;

	// serial and parallel readout timing after the power-down edge
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pd_prev            <= 1'b0;
			ro_active          <= 1'b0;
			ro_cnt             <= 6'h00;
			ro_snap            <= 8'h00;
			serial_result      <= 1'b0;
			serial_result_oe_n <= 1'b1;
			parallel_result    <= 8'h00;
			parallel_valid     <= 1'b0;
		end else begin
			pd_prev <= power_down_route;
			if (power_down_route && !pd_prev) begin
				ro_active      <= 1'b1;
				ro_cnt         <= 6'h00;
				ro_snap        <= last_result;
				parallel_valid <= 1'b0;
			end else if (!power_down_route) begin
				// released early by the matrix: abandon the transfer
				ro_active          <= 1'b0;
				serial_result_oe_n <= 1'b1;
				parallel_valid     <= 1'b0;
			end else if (ro_active && tick) begin
				ro_cnt <= next_ro_cnt;
				// bits msb first on ticks 3..10, driven to the pin
				if (next_ro_cnt >= 6'(SER_WAIT_TICKS)
					&& next_ro_cnt < 6'(SER_WAIT_TICKS + RESULT_BITS)) begin
					serial_result      <= ro_snap[3'(6'd10 - next_ro_cnt)];
					serial_result_oe_n <= 1'b0;
				end else begin
					serial_result_oe_n <= 1'b1;
				end
				// parallel word at tick ten
				if (next_ro_cnt == 6'(PAR_WAIT_TICKS)) begin
					parallel_result <= ro_snap;
					parallel_valid  <= 1'b1;
				end
				if (next_ro_cnt == 6'(PAR_HOLD_TICKS)) begin
					ro_active <= 1'b0;
				end
			end
		end
	end

	// trim converter code source
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			trim_code <= TRIM_RESET;
		end else if (cfg.trim_src_sel) begin
			trim_code <= dcmp1_input;
		end else begin
			trim_code <= trim_reg;
		end
	end

	// analog front-end steering, registered
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			analog_ctrl <= '0;
		end else begin
			analog_ctrl.diff_mode      <= cfg.differential;
			analog_ctrl.neg_from_trim  <= cfg.differential & cfg.pseudo_diff_en;
			analog_ctrl.pos_from_first <= ~cfg.multichannel_en | channel_select_pin;
			analog_ctrl.native_trim_in <= cfg.native_trim_in;
			analog_ctrl.pga_out_en     <= cfg.pga_out_en;
			analog_ctrl.gain_code      <= cfg.gain_sel;
			analog_ctrl.vref_code      <= cfg.vref_sel;
			analog_ctrl.vref_valid     <= (cfg.vref_sel != REF_NONE)
				&& (cfg.vref_sel != REF_QUARTER || cfg.vdd_div_en);
		end
	end

endmodule

// >>> tb/sacs_matrix_model.sv
// behavioural matrix logic that requests and collects results
`timescale 1ns/1ps

module sacs_matrix_model (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       start,
	input  wire logic [5:0] hold_ticks,
	input  wire logic       serial_result,
	input  wire logic       serial_result_oe_n,
	input  wire logic [7:0] parallel_result,
	input  wire logic       parallel_valid,
	output logic            matrix_clock_route,
	output logic            power_down_route,
	output logic            busy,
	output logic      [7:0] captured,
	output logic      [7:0] par_word,
	output logic      [5:0] first_bit_tick,
	output logic      [5:0] valid_tick
);
	logic [1:0] phase;
	logic [5:0] ticks;

	// free-running clock at clk/4, periodic conversions need it
	always_ff @(posedge clk) begin
		phase <= rst_n ? phase + 2'h1 : 2'h0;
	end
	assign matrix_clock_route = phase[1];

	// request held hold_ticks ticks, outputs sampled at each rising tick
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			power_down_route <= 1'b0;
			busy             <= 1'b0;
		end else if (!busy && start && phase == 2'h3) begin
			power_down_route <= 1'b1;
			busy             <= 1'b1;
			ticks            <= 6'h0;
			first_bit_tick   <= 6'h0;
			valid_tick       <= 6'h0;
		end else if (busy && phase == 2'h1) begin
			ticks <= ticks + 6'h1;
			if (!serial_result_oe_n) begin
				captured <= {captured[6:0], serial_result};
			end
			if (!serial_result_oe_n && first_bit_tick == 6'h0) begin
				first_bit_tick <= ticks + 6'h1;
			end
			if (parallel_valid && valid_tick == 6'h0) begin
				valid_tick <= ticks + 6'h1;
				par_word   <= parallel_result;
			end
			if (ticks + 6'h1 == hold_ticks) begin
				power_down_route <= 1'b0;
				busy             <= 1'b0;
			end
		end
	end
endmodule

// >>> tb/sacs_sequencer_assertions.sv
// port-level assertions for the converter control sequencer
`timescale 1ns/1ps

module sacs_sequencer_checker (
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic       power_down_route,
	input wire logic       adc_power_down,
	input wire logic       pga_power_down,
	input wire logic       analog_block_on,
	input wire logic       serial_result_oe_n,
	input wire logic [7:0] parallel_result,
	input wire logic       parallel_valid,
	input wire logic       conversion_irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// interrupt, power and readout relations
	a_irq_one_pulse: assert property (conversion_irq |=> !conversion_irq)
		else $error("irq too long");
	a_pd_needs_route: assert property (!power_down_route |-> !adc_power_down)
		else $error("power-down unasked");
	a_pd_both_parts: assert property (adc_power_down == pga_power_down)
		else $error("amplifier differs");
	a_analog_stays_on: assert property (!adc_power_down |-> analog_block_on)
		else $error("analog off");
	a_serial_after_route: assert property ($fell(serial_result_oe_n) |-> $past(power_down_route))
		else $error("serial unasked");
	a_valid_with_lsb: assert property ($rose(parallel_valid) |-> !serial_result_oe_n)
		else $error("word not at last bit");
	a_serial_first: assert property ($fell(serial_result_oe_n) |-> !parallel_valid)
		else $error("word before bits");
	a_word_steady: assert property (parallel_valid ##1 parallel_valid |-> $stable(parallel_result))
		else $error("word moved");
	c_conversion: cover property (conversion_irq);
	c_serial: cover property ($fell(serial_result_oe_n));
	c_parallel: cover property ($rose(parallel_valid));
endmodule

// >>> tb/sacs_sequencer_tb.sv
// self-checking bench for the converter control sequencer
`timescale 1ns/1ps

bind sacs_sequencer sacs_sequencer_checker u_chk (
	.clk                (clk),
	.rst_n              (rst_n),
	.power_down_route   (power_down_route),
	.adc_power_down     (adc_power_down),
	.pga_power_down     (pga_power_down),
	.analog_block_on    (analog_block_on),
	.serial_result_oe_n (serial_result_oe_n),
	.parallel_result    (parallel_result),
	.parallel_valid     (parallel_valid),
	.conversion_irq     (conversion_irq)
);

module sacs_sequencer_tb
	import sacs_pkg::*;
;
	localparam int FIRST_ON = 50;
	logic            clk = 1'b0;
	logic            rst_n = 1'b0;
	logic [3:0]      reg_addr = 4'h0;
	logic [31:0]     reg_wdata = 32'h0;
	logic            reg_write = 1'b0;
	logic            reg_read = 1'b0;
	logic            channel_select_pin = 1'b0;
	logic [7:0]      dcmp1_input = 8'h3C;
	logic [7:0]      analog_in = 8'h5A;
	logic [3:0]      src_en = 4'h0;
	logic            start = 1'b0;
	logic [5:0]      hold_ticks = 6'h0;
	logic [31:0]     reg_rdata, rdata;
	logic            ring_osc, matrix_clock_route, rc_osc, spi_sclk, power_down_route;
	logic            comparator_high, adc_power_down, pga_power_down, analog_block_on;
	logic            sample_hold, serial_result, serial_result_oe_n, parallel_valid;
	logic            conversion_irq, busy, got;
	logic [7:0]      sar_trial, trim_code, parallel_result, captured, par_word;
	logic [5:0]      first_bit_tick, valid_tick;
	sacs_analog_type analog_ctrl, exp_ctrl;
	sacs_config_type cfg;
	int              miscompares = 0;
	int              comparisons = 0;
	int              cyc;

	always #10 clk = ~clk;
	// gated copies of the matrix clock, ideal comparator
	assign ring_osc = src_en[0] & matrix_clock_route;
	assign rc_osc = src_en[2] & matrix_clock_route;
	assign spi_sclk = src_en[3] & matrix_clock_route;
	assign comparator_high = (analog_in >= sar_trial);

	sacs_sequencer #(.FIRST_ON_CYCLES(FIRST_ON), .RATE_5K(100), .RATE_10K(80),
		.RATE_20K(60), .RATE_100K(40)) dut (
		.clk                (clk),
		.rst_n              (rst_n),
		.reg_addr           (reg_addr),
		.reg_wdata          (reg_wdata),
		.reg_write          (reg_write),
		.reg_read           (reg_read),
		.reg_rdata          (reg_rdata),
		.ring_osc           (ring_osc),
		.matrix_clock_route (matrix_clock_route),
		.rc_osc             (rc_osc),
		.spi_sclk           (spi_sclk),
		.power_down_route   (power_down_route),
		.channel_select_pin (channel_select_pin),
		.dcmp1_input        (dcmp1_input),
		.comparator_high    (comparator_high),
		.analog_ctrl        (analog_ctrl),
		.adc_power_down     (adc_power_down),
		.pga_power_down     (pga_power_down),
		.analog_block_on    (analog_block_on),
		.sample_hold        (sample_hold),
		.sar_trial          (sar_trial),
		.trim_code          (trim_code),
		.serial_result      (serial_result),
		.serial_result_oe_n (serial_result_oe_n),
		.parallel_result    (parallel_result),
		.parallel_valid     (parallel_valid),
		.conversion_irq     (conversion_irq)
	);
	sacs_matrix_model partner (
		.clk                (clk),
		.rst_n              (rst_n),
		.start              (start),
		.hold_ticks         (hold_ticks),
		.serial_result      (serial_result),
		.serial_result_oe_n (serial_result_oe_n),
		.parallel_result    (parallel_result),
		.parallel_valid     (parallel_valid),
		.matrix_clock_route (matrix_clock_route),
		.power_down_route   (power_down_route),
		.busy               (busy),
		.captured           (captured),
		.par_word           (par_word),
		.first_bit_tick     (first_bit_tick),
		.valid_tick         (valid_tick)
	);

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		#1 d = reg_rdata;
	endtask

	task automatic wait_irq(output logic seen);
		seen = 1'b0;
		for (int n = 0; n < 400 && !seen; n++) begin
			@(negedge clk);
			seen = (conversion_irq === 1'b1);
		end
	endtask

	task automatic readout(input logic [5:0] ticks, input logic fast);
		@(posedge clk);
		hold_ticks <= ticks;
		start <= 1'b1;
		repeat (24) @(posedge clk);
		start <= 1'b0;
		@(negedge clk);
		check(adc_power_down, 1'b1);
		check(pga_power_down, 1'b1);
		check(analog_block_on, fast);
		for (int n = 0; n < 400 && busy; n++) @(negedge clk);
		check(captured, analog_in);
		check(par_word, analog_in);
		check(first_bit_tick, SER_WAIT_TICKS + 1);
		check(valid_tick, PAR_WAIT_TICKS + 1);
		rd(ADDR_STATUS, rdata);
		check(rdata[9], 1'b0);
		repeat (fast ? 260 : FIRST_ON + 10) @(posedge clk);
		rd(ADDR_STATUS, rdata);
		check(rdata[9], 1'b1);
	endtask

	task automatic complete_run();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		rd(ADDR_CONFIG, rdata);
		check(rdata, 32'(CONFIG_RESET));
		rd(4'hF, rdata);
		check(rdata, 32'h0);
		check(serial_result_oe_n, 1'b1);
		wr(ADDR_TRIM, 32'hA5);
		rd(ADDR_TRIM, rdata);
		check(rdata, 32'hA5);
		check(trim_code, 8'hA5);
		cfg = '0;
		for (int i = 0; i < 4; i++) begin
			cfg.differential = i[0];
			cfg.native_trim_in = i[0];
			cfg.multichannel_en = i[1];
			cfg.trim_src_sel = i[1];
			cfg.pga_out_en = i[1];
			cfg.pseudo_diff_en = 1'b1;
			cfg.gain_sel = 3'(2 * i + 1);
			cfg.vref_sel = 2'(i);
			channel_select_pin <= !i[0];
			wr(ADDR_CONFIG, 32'(cfg));
			repeat (2) @(negedge clk);
			exp_ctrl = '{i[0], i[0], i != 3, i[0], i[1], 3'(2 * i + 1), 2'(i), i < 2};
			check(analog_ctrl, exp_ctrl);
			check(trim_code, i[1] ? dcmp1_input : 8'hA5);
			rd(ADDR_CONFIG, rdata);
			check(rdata, 32'(cfg));
		end
		// each clock source code, then an idle source
		cfg = '0;
		cfg.wake_sleep_en = 1'b1;
		for (int i = 0; i < 5; i++) begin
			src_en <= (i < 4) ? 4'(1 << i) : 4'h1;
			cfg.clk_sel = (i < 4) ? 2'(i) : CLK_RC;
			cfg.speed_sel = 2'(i);
			wr(ADDR_CONFIG, 32'(cfg));
			wait_irq(got);
			check(got, i < 4);
		end
		cfg.clk_sel = CLK_MATRIX;
		wr(ADDR_CONFIG, 32'(cfg));
		wait_irq(got);
		// sample to result spans sixteen ticks of the clk/4 matrix clock
		@(posedge sample_hold);
		cyc = 0;
		@(negedge clk);
		while (conversion_irq !== 1'b1 && cyc < 200) begin
			@(negedge clk);
			cyc++;
		end
		check(cyc, (CONV_TICKS - 1) * 4);
		rd(ADDR_STATUS, rdata);
		check(rdata[7:0], analog_in);
		readout(6'h20, 1'b0);
		cfg.fast_power_on = 1'b1;
		wr(ADDR_CONFIG, 32'(cfg));
		readout(6'h10, 1'b1);
		complete_run();
	end

	// watchdog well above the expected run length
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		complete_run();
	end
endmodule
